//--- logic/bridge_cfg_tail.sv
// Configuration header tail of a PCI Express to PCI bridge, offsets 30h to 3Fh.
// Notes on behaviour
// - The upper I/O limit register at 32h is 16 bits read/write and resets to zero.
// - The composed I/O limit fills its low 20 address bits with ones.
// - The capabilities pointer at 34h always reads 50h.
// - The interrupt line register at 3Ch resets to FFh and is only software storage.
// - The interrupt pin register at 3Dh always reads zero.
// - Secondary side interrupts pass to the primary side through three register stages, three clocks late.
// - Bridge control at 3Eh resets to zero and its bits 15 to 12 read zero.
// - With bit 11 set in conventional mode a discard sends an error message upstream, non-fatal by default.
// - The message severity is selectable only when advanced error reporting exists, else non-fatal.
// - With bit 11 clear a message is still sent if advanced reporting exists and mask bit 10 is clear.
// - Bit 10 of bridge control is set by a discard and stays set until software clears it.
// - Bit 9 selects a discard period of 2^15 clocks when zero and 2^10 when one.
// - The upper I/O base register at 30h is read/write, resets to zero, and fills low bits with zeros.
`timescale 1ns/10ps
`include "bridge_cfg_tail_regs.svh"
module bridge_cfg_tail (
  input wire logic clk,
  input wire logic rst_b,
  input wire bridge_cfg_tail_pkg::cfg_req_s cfg_req,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  output logic cfg_hit,
  input wire logic conventional_mode,
  input wire logic aer_supported,
  input wire logic [31:0] sec_uncorr_err_mask,
  input wire logic aer_discard_fatal,
  input wire logic discard_event,
  output bridge_cfg_tail_pkg::err_msg_s err_msg,
  output logic secondary_discard_period_sel,
  output logic [4:0] discard_period_log2,
  input wire logic [35:0] io_addr,
  output logic io_forward,
  input wire logic [3:0] sec_irq_b,
  output logic [3:0] pri_irq_b,
  output logic [15:0] io_window_top_high_field,
  output logic [15:0] io_window_bottom_high_field
);
  // ****************************************************************
  // Register storage and write decode
  // ****************************************************************
  logic [15:0] io_bottom_q;
  logic [15:0] io_top_q;
  logic [7:0] irq_scratch_q;
  logic [15:0] bctrl_q;
  logic [3:0] irq_s1_q;
  logic [3:0] irq_s2_q;

  function automatic logic word_hit(input logic [7:0] a, input logic [7:0] ofs);
    word_hit = (a[7:2] == ofs[7:2]);
  endfunction

  logic sel_30;
  logic sel_3c;
  assign sel_30 = word_hit(cfg_req.addr, `OFS_IO_BOTTOM_HIGH);
  assign sel_3c = word_hit(cfg_req.addr, `OFS_IRQ_ROUTING_SCRATCH);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      io_bottom_q <= `RST_IO_BOTTOM_HIGH;
      io_top_q <= `RST_IO_TOP_HIGH;
    end else if (cfg_req.wr && sel_30) begin
      if (cfg_req.be[0]) io_bottom_q[7:0] <= cfg_req.wdata[7:0];
      if (cfg_req.be[1]) io_bottom_q[15:8] <= cfg_req.wdata[15:8];
      if (cfg_req.be[2]) io_top_q[7:0] <= cfg_req.wdata[23:16];
      if (cfg_req.be[3]) io_top_q[15:8] <= cfg_req.wdata[31:24];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_scratch_q <= `RST_IRQ_ROUTING_SCRATCH;
    end else if (cfg_req.wr && sel_3c && cfg_req.be[0]) begin
      irq_scratch_q <= cfg_req.wdata[7:0];
    end
  end

  // ****************************************************************
  // Bridge control
  // ****************************************************************
  // Writing one to the status bit clears it, but a discard in the same cycle wins so no event is lost.
  logic [15:0] bctrl_d;
  logic clr_flag;
  always_comb begin
    bctrl_d = bctrl_q;
    clr_flag = 1'b0;
    if (cfg_req.wr && sel_3c) begin
      if (cfg_req.be[2]) bctrl_d[7:0] = cfg_req.wdata[23:16];
      if (cfg_req.be[3]) begin
        bctrl_d[15:8] = cfg_req.wdata[31:24];
        clr_flag = cfg_req.wdata[16 + `BIT_DISCARD_FLAG];
      end
    end
    bctrl_d = bctrl_d & `BRIDGE_CTRL_RW_MASK;
    bctrl_d[`BIT_DISCARD_FLAG] = discard_event | (bctrl_q[`BIT_DISCARD_FLAG] & ~clr_flag);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bctrl_q <= `RST_BRIDGE_CTRL;
    end else begin
      bctrl_q <= bctrl_d;
    end
  end

  assign secondary_discard_period_sel = bctrl_q[`BIT_PERIOD_SEL];
  // The timer itself lives elsewhere; it is handed the period as a power of two.
  assign discard_period_log2 = bctrl_q[`BIT_PERIOD_SEL] ? 5'(`DISCARD_SHORT_LOG2) : 5'(`DISCARD_LONG_LOG2);

  // ****************************************************************
  // Discard error message
  // ****************************************************************
  logic msg_want;
  assign msg_want = (conventional_mode && bctrl_q[`BIT_ERR_MSG_EN]) ||
                    (aer_supported && !sec_uncorr_err_mask[`DISCARD_MASK_BIT]);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      err_msg <= '0;
    end else begin
      err_msg.send <= discard_event && msg_want;
      err_msg.fatal <= discard_event && msg_want && aer_supported && aer_discard_fatal;
    end
  end

  // ****************************************************************
  // Interrupt pass-through
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_s1_q <= 4'hf;
      irq_s2_q <= 4'hf;
      pri_irq_b <= 4'hf;
    end else begin
      irq_s1_q <= sec_irq_b;
      irq_s2_q <= irq_s1_q;
      pri_irq_b <= irq_s2_q;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Reads answer one cycle after the request; unmapped words return zero with cfg_hit low.
  logic [31:0] rdata_d;
  logic hit_d;
  always_comb begin
    rdata_d = 32'h0000_0000;
    hit_d = 1'b1;
    case (cfg_req.addr[7:2])
      6'(`OFS_IO_BOTTOM_HIGH >> 2): rdata_d = {io_top_q, io_bottom_q};
      6'(`OFS_CAP_LIST_POINTER >> 2): rdata_d = {24'h00_0000, `VAL_CAP_LIST_POINTER};
      6'(`OFS_IRQ_ROUTING_SCRATCH >> 2): rdata_d = {bctrl_q & `BRIDGE_CTRL_RW_MASK | (bctrl_q & 16'h0400),
                                                    `VAL_IRQ_PIN_CODE, irq_scratch_q};
      default: hit_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_rdata <= 32'h0000_0000;
      cfg_rvalid <= 1'b0;
      cfg_hit <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_req.rd;
      cfg_hit <= cfg_req.rd && hit_d;
      cfg_rdata <= cfg_req.rd ? rdata_d : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Forwarding window
  // ****************************************************************
  assign io_window_top_high_field = io_top_q;
  assign io_window_bottom_high_field = io_bottom_q;

  io_window_check u_win (
    .bottom_high(io_bottom_q),
    .top_high(io_top_q),
    .io_addr(io_addr),
    .in_window(io_forward)
  );
endmodule

//--- logic/bridge_cfg_tail_regs.svh
// Offsets, field positions, reset values and counts of the bridge configuration header tail.
`ifndef BRIDGE_CFG_TAIL_REGS_SVH
`define BRIDGE_CFG_TAIL_REGS_SVH
`define OFS_IO_BOTTOM_HIGH 8'h30
`define OFS_IO_TOP_HIGH 8'h32
`define OFS_CAP_LIST_POINTER 8'h34
`define OFS_IRQ_ROUTING_SCRATCH 8'h3c
`define OFS_IRQ_PIN_CODE 8'h3d
`define OFS_BRIDGE_CTRL 8'h3e
`define RST_IO_BOTTOM_HIGH 16'h0000
`define RST_IO_TOP_HIGH 16'h0000
`define VAL_CAP_LIST_POINTER 8'h50
`define RST_IRQ_ROUTING_SCRATCH 8'hff
`define VAL_IRQ_PIN_CODE 8'h00
`define RST_BRIDGE_CTRL 16'h0000
`define BIT_ERR_MSG_EN 11
`define BIT_DISCARD_FLAG 10
`define BIT_PERIOD_SEL 9
`define BRIDGE_CTRL_RW_MASK 16'h0bff
`define IO_LOW_BITS 20
`define IO_LIMIT_LOW_FILL 20'hf_ffff
`define IO_BASE_LOW_FILL 20'h0_0000
`define DISCARD_MASK_BIT 10
`define DISCARD_LONG_LOG2 15
`define DISCARD_SHORT_LOG2 10
`endif

//--- logic/bridge_cfg_tail_pkg.sv
// Types shared by the bridge configuration header tail.
package bridge_cfg_tail_pkg;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_s;
  typedef struct packed {
    logic send;
    logic fatal;
  } err_msg_s;
endpackage

//--- logic/io_window_check.sv
// Inclusive I/O forwarding window comparison.
`timescale 1ns/10ps
`include "bridge_cfg_tail_regs.svh"
module io_window_check (
  input wire logic [15:0] bottom_high,
  input wire logic [15:0] top_high,
  input wire logic [35:0] io_addr,
  output logic in_window
);
  logic [35:0] lo;
  logic [35:0] hi;
  assign lo = {bottom_high, `IO_BASE_LOW_FILL};
  assign hi = {top_high, `IO_LIMIT_LOW_FILL};
  assign in_window = (io_addr >= lo) && (io_addr <= hi);
endmodule

//--- bench/cfg_host.sv
// Host side model that issues configuration reads and writes.
`timescale 1ns/10ps
module cfg_host (
  input wire logic clk,
  output bridge_cfg_tail_pkg::cfg_req_s cfg_req
);
  initial cfg_req = '0;
  // The strobe drops for a cycle between calls, so one read never merges with the next request.
  task automatic xfer(input logic rd, input logic [7:0] addr, input logic [3:0] be, input logic [31:0] wdata);
    @(posedge clk);
    cfg_req <= {rd, ~rd, addr, be, wdata};
    @(posedge clk);
    cfg_req <= '0;
  endtask
endmodule

//--- bench/bridge_cfg_tail_properties.sv
// Port checks of the bridge configuration header tail.
`timescale 1ns/10ps
module bridge_cfg_tail_properties (
  input wire logic clk,
  input wire logic rst_b,
  input wire bridge_cfg_tail_pkg::cfg_req_s cfg_req,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_hit,
  input wire logic aer_supported,
  input wire logic [31:0] sec_uncorr_err_mask,
  input wire logic discard_event,
  input wire bridge_cfg_tail_pkg::err_msg_s err_msg,
  input wire logic secondary_discard_period_sel,
  input wire logic [4:0] discard_period_log2,
  input wire logic [3:0] sec_irq_b,
  input wire logic [3:0] pri_irq_b
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence cap_rd; cfg_req.rd && cfg_req.addr[7:2] == 6'h0d; endsequence
  sequence ctl_rd; cfg_req.rd && cfg_req.addr[7:2] == 6'h0f; endsequence
  a_cap_ptr_const: assert property (cap_rd |=> cfg_hit && cfg_rdata == 32'h0000_0050) else $error("cap ptr");
  a_pin_rsvd_zero: assert property (ctl_rd |=> cfg_rdata[15:8] == 8'h00 && cfg_rdata[31:28] == 4'h0)
    else $error("pin or reserved");
  a_flag_sticky: assert property (discard_event ##1 !cfg_req.wr ##1 ctl_rd |=> cfg_rdata[26]) else $error("flag");
  a_send_cause: assert property (err_msg.send |-> $past(discard_event)) else $error("send cause");
  a_send_masked: assert property (discard_event && aer_supported && !sec_uncorr_err_mask[10] |=> err_msg.send)
    else $error("send aer");
  a_fatal_aer: assert property (err_msg.fatal |-> err_msg.send && $past(aer_supported)) else $error("fatal");
  a_period_map: assert property (discard_period_log2 == (secondary_discard_period_sel ? 5'ha : 5'hf))
    else $error("period");
  a_irq_pass: assert property (pri_irq_b == $past(sec_irq_b, 3)) else $error("irq");
endmodule
bind bridge_cfg_tail bridge_cfg_tail_properties bridge_cfg_tail_properties_i (.clk(clk), .rst_b(rst_b),
  .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit), .aer_supported(aer_supported),
  .sec_uncorr_err_mask(sec_uncorr_err_mask), .discard_event(discard_event), .err_msg(err_msg),
  .secondary_discard_period_sel(secondary_discard_period_sel), .discard_period_log2(discard_period_log2),
  .sec_irq_b(sec_irq_b), .pri_irq_b(pri_irq_b));

//--- bench/bridge_cfg_tail_bench.sv
// Self-checking bench of the bridge configuration header tail.
`timescale 1ns/10ps
module bridge_cfg_tail_bench;
  logic clk, rst_b, conv, aer, fatal, disc, rvalid, hit, sel, fwd;
  logic [31:0] mask, rdata;
  logic [35:0] io_addr;
  logic [4:0] plog;
  logic [3:0] sec_b, pri_b, irq;
  logic [15:0] wtop, wbot, t, b;
  bridge_cfg_tail_pkg::cfg_req_s req;
  bridge_cfg_tail_pkg::err_msg_s msg;
  logic [32:0] exp_q[$];
  int miscompares, tests_run, cycles;
  bridge_cfg_tail bridge_cfg_tail_i (.clk(clk), .rst_b(rst_b), .cfg_req(req), .cfg_rdata(rdata), .cfg_rvalid(rvalid),
    .cfg_hit(hit), .conventional_mode(conv), .aer_supported(aer), .sec_uncorr_err_mask(mask), .aer_discard_fatal(fatal),
    .discard_event(disc), .err_msg(msg), .secondary_discard_period_sel(sel), .discard_period_log2(plog),
    .io_addr(io_addr), .io_forward(fwd), .sec_irq_b(sec_b), .pri_irq_b(pri_b), .io_window_top_high_field(wtop),
    .io_window_bottom_high_field(wbot));
  cfg_host cfg_host_i (.clk(clk), .cfg_req(req));
  task automatic chk(input string what, input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] exp);
    exp_q.push_back(exp);
    cfg_host_i.xfer(1'b1, a, 4'hf, 32'h0000_0000);
  endtask
  task automatic pulse(input logic aer_v, input logic [31:0] mask_v);
    @(posedge clk);
    aer <= aer_v;
    mask <= mask_v;
    disc <= 1'b1;
    @(posedge clk);
    disc <= 1'b0;
    @(negedge clk);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ****
  // Clock, read answer monitor and hang limit.
  // ****
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (rvalid === 1'b1) begin
      chk("read", {hit, rdata}, exp_q.pop_front());
    end
    if (cycles == 3000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    {rst_b, aer, fatal, disc, mask, io_addr} = '0;
    conv = 1'b1;
    sec_b = 4'hf;
    void'($urandom(32'he477_015c));
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rd(8'h30, 33'h1_0000_0000);
    rd(8'h34, 33'h1_0000_0050);
    rd(8'h3c, 33'h1_0000_00ff);
    rd(8'h38, 33'h0_0000_0000);
    b = 16'($urandom_range(16'h7fff, 1));
    t = b + 16'($urandom_range(255, 0));
    cfg_host_i.xfer(1'b0, 8'h30, 4'hf, {t, b});
    rd(8'h30, {1'b1, t, b});
    chk("window", 33'({wtop, wbot}), 33'({t, b}));
    // Each edge of the window is probed from both sides, since an off-by-one hides at the ends.
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      io_addr <= i[1] ? {t, 20'hf_ffff} + 36'(i[0]) : {b, 20'h0_0000} - 36'(i[0]);
      @(negedge clk);
      chk("io_forward", 33'(fwd), 33'(!i[0]));
    end
    cfg_host_i.xfer(1'b0, 8'h3c, 4'hf, 32'hffff_ffaa);
    rd(8'h3c, 33'h1_0bff_00aa);
    chk("period", {27'h0, sel, plog}, 33'h2a);
    pulse(1'b0, 32'h0000_0000);
    chk("err_msg", 33'(msg), 33'h2);
    rd(8'h3c, 33'h1_0fff_00aa);
    cfg_host_i.xfer(1'b0, 8'h3c, 4'hc, 32'h0400_0000);
    rd(8'h3c, 33'h1_0000_00aa);
    fatal <= 1'b1;
    pulse(1'b1, 32'h0000_0000);
    chk("err_msg", 33'(msg), 33'h3);
    pulse(1'b1, 32'h0000_0400);
    chk("err_msg", 33'(msg), 33'h0);
    // Bit 11 must stay silent outside conventional mode, and without advanced reporting the severity input is ignored.
    cfg_host_i.xfer(1'b0, 8'h3c, 4'h8, 32'h0800_0000);
    chk("period", {27'h0, sel, plog}, 33'h0f);
    conv <= 1'b0;
    pulse(1'b0, 32'h0000_0000);
    chk("err_msg", 33'(msg), 33'h0);
    @(posedge clk);
    conv <= 1'b1;
    pulse(1'b0, 32'h0000_0000);
    chk("err_msg", 33'(msg), 33'h2);
    // A clear that meets a discard in the same cycle must lose, or the event would vanish unseen.
    fork
      cfg_host_i.xfer(1'b0, 8'h3c, 4'h8, 32'h0400_0000);
      pulse(1'b0, 32'h0000_0000);
    join
    rd(8'h3c, 33'h1_0400_00aa);
    repeat (3) begin
      @(posedge clk);
      irq = 4'($urandom);
      sec_b <= irq;
      repeat (4) @(negedge clk);
      chk("pri_irq_b", 33'(pri_b), 33'(irq));
    end
    repeat (3) @(posedge clk);
    chk("pending reads", 33'(exp_q.size()), 33'h0);
    tally_and_finish();
  end
endmodule
